// *** src/i2c_target.sv ***
// i2c register access target with auto-incrementing pointer
// Operation
// (R1) ack device address and register pointer byte
// (R2) host repeated start, address with read
// (R3) send register selected by pointer after ack
// (R4) host naks single byte, then stop
// (R5) read pointer advances after every byte
// (R6) burst read until nak then stop
// (R7) host writes address, pointer, then data
// (R8) ack each write data byte on ninth clock
// (R9) commit write byte at pointer address; here bytes arriving while the write buffer is full are dropped
// (R10) write pointer advances after each byte; here only for bytes pushed into the write buffer
// (R11) select pins choose one of four addresses
// (R12) never hold clock low
// (R13) receiver pulls data low on ninth clock
// (R14) mismatch: release data, wait next start
`timescale 1ns/1ns
module i2c_target #(
  parameter int DEPTH = 256
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  // address select straps
  input wire logic ADDRESS_SELECT_HIGH_I,
  input wire logic ADDRESS_SELECT_LOW_I,
  // i2c bus pins
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic SCL_O,
  output logic SCL_OE_O,
  // received write bytes
  output logic WR_VALID_O,
  output logic [7:0] WR_ADDR_O,
  output logic [7:0] WR_DATA_O,
  input wire logic WR_READY_I
);
  localparam int DW = i2c_target_pkg::DATA_W;
  localparam int AW = i2c_target_pkg::PTR_W;

  initial begin
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin
      $error("unsupported register depth");
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVADDR, ST_PTR, ST_WDATA, ST_RACK, ST_RDATA, ST_IGNORE
  } state_type;

  // ----------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------
  logic [1:0] scl_sync_ff, sda_sync_ff, sel_sync_ff, sel_meta_ff;
  logic scl_d_ff, sda_d_ff;
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      sel_meta_ff <= 2'h0;
      sel_sync_ff <= 2'h0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else if (CE_I) begin
      scl_sync_ff <= {scl_sync_ff[0], SCL_I};
      sda_sync_ff <= {sda_sync_ff[0], SDA_I};
      sel_meta_ff <= {ADDRESS_SELECT_HIGH_I, ADDRESS_SELECT_LOW_I};
      sel_sync_ff <= sel_meta_ff;
      scl_d_ff <= scl_sync_ff[1];
      sda_d_ff <= sda_sync_ff[1];
    end
  end

  wire scl = scl_sync_ff[1];
  wire sda = sda_sync_ff[1];
  wire scl_rise = scl & ~scl_d_ff;
  wire scl_fall = ~scl & scl_d_ff;
  wire start_det = scl & scl_d_ff & sda_d_ff & ~sda;
  wire stop_det = scl & scl_d_ff & ~sda_d_ff & sda;

  // ----------------------------------------
  // own address decode
  // ----------------------------------------
  function automatic logic [6:0] own_addr(input logic [1:0] sel);
    case (sel)
      2'h0: own_addr = i2c_target_pkg::ADDR_SEL_00;
      2'h1: own_addr = i2c_target_pkg::ADDR_SEL_01;
      2'h2: own_addr = i2c_target_pkg::ADDR_SEL_10;
      default: own_addr = i2c_target_pkg::ADDR_SEL_11;
    endcase
  endfunction
  wire [6:0] my_addr = own_addr(sel_sync_ff); // [R11]

  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  state_type state_ff, nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [AW-1:0] ptr_ff;
  logic [7:0] tx_ff;
  logic sda_oe_ff, host_ack_ff;
  logic [DW-1:0] mem_rdata;

  wire ack_slot = (bit_cnt_ff == i2c_target_pkg::ACK_BIT);
  wire [7:0] rx_byte = {shift_ff[6:0], sda};
  wire byte_done = scl_rise & (bit_cnt_ff == 4'h7);
  wire addr_hit = (rx_byte[7:1] == my_addr);

  // ack own slots; read bits go out msb first
  wire own_ack = ack_slot & ((state_ff == ST_PTR) | (state_ff == ST_WDATA) |
                             (state_ff == ST_RACK)); // [R1] [R8] [R13]
  wire load_tx = (state_ff == ST_RDATA) & (bit_cnt_ff == 4'h0) &
                 host_ack_ff; // [R5]
  wire send_bit = (state_ff == ST_RDATA) & ~ack_slot & (bit_cnt_ff != 4'h0);
  wire [2:0] tx_idx = 3'h7 - bit_cnt_ff[2:0];
  wire nxt_sda_oe = own_ack | (load_tx & ~mem_rdata[7]) |
                    (send_bit & ~tx_ff[tx_idx]); // [R3] [R14]

  // two-entry write buffer
  logic [1:0] fifo_cnt_ff;
  logic [15:0] fifo_ff [2];
  wire fifo_full = (fifo_cnt_ff == 2'h2);
  wire push = (state_ff == ST_WDATA) & byte_done & ~fifo_full;
  wire pop = WR_VALID_O & WR_READY_I;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = ST_IDLE;
      ST_DEVADDR: begin
        if (byte_done) begin
          if (!addr_hit) begin
            nxt_state = ST_IGNORE; // [R14]
          end else if (rx_byte[0]) begin
            nxt_state = ST_RACK; // [R3]
          end else begin
            nxt_state = ST_PTR; // [R1]
          end
        end
      end
      ST_PTR: begin
        if (byte_done) begin
          nxt_state = ST_WDATA;
        end
      end
      ST_WDATA: nxt_state = ST_WDATA;
      ST_RACK: begin
        if (scl_rise && ack_slot) begin
          nxt_state = ST_RDATA; // [R1]
        end
      end
      ST_RDATA: begin
        if (scl_rise && ack_slot && sda) begin
          nxt_state = ST_IGNORE; // [R6]
        end
      end
      ST_IGNORE: nxt_state = ST_IGNORE;
      default: nxt_state = ST_IDLE;
    endcase
    if (stop_det) begin
      nxt_state = ST_IDLE;
    end
    if (start_det) begin
      nxt_state = ST_DEVADDR;
    end
  end

  reg_store #(
    .DEPTH(DEPTH),
    .AW(AW),
    .DW(DW)
  ) u_store (
    .clk_i(MCLK_I),
    .en_i(CE_I),
    .we_i(pop),
    .waddr_i(fifo_ff[0][15:8]),
    .wdata_i(fifo_ff[0][7:0]),
    .raddr_i(ptr_ff),
    .rdata_o(mem_rdata)
  );

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= i2c_target_pkg::PTR_RESET;
      tx_ff <= i2c_target_pkg::DATA_RESET;
      sda_oe_ff <= 1'b0;
      host_ack_ff <= 1'b0;
    end else if (CE_I) begin
      state_ff <= nxt_state;
      if (start_det || stop_det) begin
        bit_cnt_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
      end else if (scl_rise) begin
        shift_ff <= rx_byte;
        bit_cnt_ff <= ack_slot ? 4'h0 : bit_cnt_ff + 4'h1;
        if (ack_slot) begin
          host_ack_ff <= ~sda;
        end
        if (state_ff == ST_PTR && byte_done) begin
          ptr_ff <= rx_byte;
        end
        if (state_ff == ST_RDATA && ack_slot) begin
          ptr_ff <= ptr_ff + 8'h01; // [R5]
        end
      end else if (scl_fall) begin
        // change drive only after scl falls; scl itself is never held [R12]
        sda_oe_ff <= nxt_sda_oe;
        if (load_tx) begin
          tx_ff <= mem_rdata; // [R3]
        end
      end
    end
  end

  // ----------------------------------------
  // write buffer and pointer advance
  // ----------------------------------------
  logic [AW-1:0] wptr_ff;
  logic wr_valid_ff;
  wire [1:0] nxt_fifo_cnt = fifo_cnt_ff + {1'b0, push} - {1'b0, pop};
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      fifo_cnt_ff <= 2'h0;
      wr_valid_ff <= 1'b0;
      fifo_ff[0] <= 16'h0000;
      fifo_ff[1] <= 16'h0000;
      wptr_ff <= i2c_target_pkg::PTR_RESET;
    end else if (CE_I) begin
      if (state_ff == ST_PTR && byte_done) begin
        wptr_ff <= rx_byte;
      end else if (push) begin
        wptr_ff <= wptr_ff + 8'h01; // [R10]
      end
      if (pop) begin
        fifo_ff[0] <= fifo_ff[1];
      end
      if (push) begin
        if (fifo_cnt_ff == 2'h0 || (fifo_cnt_ff == 2'h1 && pop)) begin
          fifo_ff[0] <= {wptr_ff, rx_byte}; // [R9]
        end else begin
          fifo_ff[1] <= {wptr_ff, rx_byte}; // [R9]
        end
      end
      fifo_cnt_ff <= nxt_fifo_cnt;
      wr_valid_ff <= (nxt_fifo_cnt != 2'h0);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic idle_drive_ff;
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      idle_drive_ff <= 1'b0;
    end else if (CE_I) begin
      idle_drive_ff <= 1'b0;
    end
  end
  assign WR_VALID_O = wr_valid_ff;
  assign WR_ADDR_O = fifo_ff[0][15:8];
  assign WR_DATA_O = fifo_ff[0][7:0];
  assign SDA_O = idle_drive_ff;
  assign SDA_OE_O = sda_oe_ff;
  assign SCL_O = idle_drive_ff;
  assign SCL_OE_O = idle_drive_ff; // [R12]
endmodule

// *** src/i2c_target_pkg.sv ***
// constants shared by the i2c register access target
package i2c_target_pkg;
  localparam logic [6:0] ADDR_SEL_00 = 7'h1e;
  localparam logic [6:0] ADDR_SEL_01 = 7'h1d;
  localparam logic [6:0] ADDR_SEL_10 = 7'h1c;
  localparam logic [6:0] ADDR_SEL_11 = 7'h1f;
  localparam int DATA_W = 8;
  localparam int PTR_W = 8;
  localparam int BIT_CNT_W = 4;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
endpackage

// *** src/reg_store.sv ***
// register store with registered read data
`timescale 1ns/1ns
module reg_store #(
  parameter int DEPTH = 256,
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) begin
      $error("depth exceeds address range");
    end
  end

  always_ff @(posedge clk_i) begin
    if (en_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

// *** testbench/i2c_target_props.sv ***
// port assertions for the i2c target
`timescale 1ns/1ns
module i2c_target_props (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  // watched ports
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic SCL_O,
  input wire logic SCL_OE_O,
  input wire logic WR_VALID_O,
  input wire logic [7:0] WR_ADDR_O,
  input wire logic [7:0] WR_DATA_O,
  input wire logic WR_READY_I
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RSTN_I);
  scl_free_a: assert property (!SCL_OE_O)
    else $error("clock line held");
  scl_zero_a: assert property (!SCL_O)
    else $error("clock driven");
  sda_od_a: assert property (!SDA_O)
    else $error("data driven high");
  oe_edge_a: assert property ($changed(SDA_OE_O) |-> !SCL_I
    && !$past(SCL_I, 2)) else $error("data moved outside clock low");
  oe_hold_a: assert property ($rose(SCL_I) |->
    $stable(SDA_OE_O)[*6]) else $error("data moved in clock high");
  wr_hold_a: assert property (WR_VALID_O && !WR_READY_I |=>
    WR_VALID_O && $stable(WR_ADDR_O) && $stable(WR_DATA_O))
    else $error("stalled word lost");
  wr_pop_a: assert property ($fell(WR_VALID_O) |-> $past(WR_READY_I))
    else $error("word left unpopped");
  val_ack_a: assert property ($rose(WR_VALID_O) |->
    $past(SDA_OE_O, 8) or (##[0:8] SDA_OE_O)) else $error("word unacked");
  cover property (WR_VALID_O && WR_READY_I);
  cover property (WR_VALID_O && !WR_READY_I);
  cover property ($rose(SDA_OE_O));
endmodule
bind i2c_target i2c_target_props i_i2c_target_props (.MCLK_I(MCLK_I),
  .RSTN_I(RSTN_I), .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .SCL_O(SCL_O), .SCL_OE_O(SCL_OE_O), .WR_VALID_O(WR_VALID_O),
  .WR_ADDR_O(WR_ADDR_O), .WR_DATA_O(WR_DATA_O), .WR_READY_I(WR_READY_I));

// *** testbench/i2c_host.sv ***
// bus host model on a pulled-up data wire
`timescale 1ns/1ns
module i2c_host (
  // target pull-down
  input wire logic sda_oe_i,
  // bus lines
  output logic scl_o,
  output logic sda_o
);
  logic sda_drv;
  assign sda_o = sda_drv & ~sda_oe_i;
  initial begin
    scl_o = 1'b1;
    sda_drv = 1'b1;
  end
  // start or repeated start, clock left low
  task automatic start();
    #4 sda_drv = 1'b1;
    #20 scl_o = 1'b1;
    #24 sda_drv = 1'b0;
    #24 scl_o = 1'b0;
  endtask
  // stop, clock then stands high
  task automatic stop();
    #4 sda_drv = 1'b0;
    #20 scl_o = 1'b1;
    #24 sda_drv = 1'b1;
    #24;
  endtask
  // msb first, ninth clock last; returns the wire
  task automatic bits9(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      #4 sda_drv = d[i];
      #20 scl_o = 1'b1;
      #12 q[i] = sda_o;
      #12 scl_o = 1'b0;
    end
  endtask
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the i2c target
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [1:0] sel;
    logic [6:0] addr;
    logic ack;
  } row_type;
  row_type rows [5] = '{{2'b00, i2c_target_pkg::ADDR_SEL_00, 1'b0},
    {2'b01, i2c_target_pkg::ADDR_SEL_01, 1'b0},
    {2'b10, i2c_target_pkg::ADDR_SEL_10, 1'b0},
    {2'b11, i2c_target_pkg::ADDR_SEL_11, 1'b0},
    {2'b00, i2c_target_pkg::ADDR_SEL_01, 1'b1}};
  localparam logic [6:0] own = i2c_target_pkg::ADDR_SEL_00;
  logic [7:0] wd [3] = '{8'ha5, 8'h3c, 8'hc3};
  logic mclk, rst_n, scl, sda, sda_oe, wr_valid, wr_ready, ce;
  logic [7:0] wr_addr, wr_data;
  logic [1:0] sel;
  logic [8:0] q;
  int errors, checks;
  i2c_target i_i2c_target (.MCLK_I(mclk), .RSTN_I(rst_n), .CE_I(ce),
    .ADDRESS_SELECT_HIGH_I(sel[1]), .ADDRESS_SELECT_LOW_I(sel[0]),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe), .SCL_O(),
    .SCL_OE_O(), .WR_VALID_O(wr_valid), .WR_ADDR_O(wr_addr),
    .WR_DATA_O(wr_data), .WR_READY_I(wr_ready));
  i2c_host i_i2c_host (.sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  task automatic check(string n, logic [8:0] e, logic [8:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wbyte(logic [7:0] b, logic e);
    i_i2c_host.bits9({b, 1'b1}, q);
    check("ack", {8'h00, e}, {8'h00, q[0]});
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // whole run is near 8 us
  initial begin
    #40000;
    errors++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'b0;
    sel = 2'b00;
    wr_ready = 1'b0;
    ce = 1'b1;
    repeat (20) @(posedge mclk);
    check("reset", 9'h000, {sda_oe, wr_valid, 7'h00});
    #1 rst_n = 1'b1;
    foreach (rows[i]) begin
      sel = rows[i].sel;
      repeat (8) @(posedge mclk);
      #1 i_i2c_host.start();
      wbyte({rows[i].addr, 1'b0}, rows[i].ack);
      i_i2c_host.stop();
    end
    i_i2c_host.start();
    wbyte({own, 1'b0}, 1'b0);
    wbyte(8'h10, 1'b0);
    foreach (wd[k]) wbyte(wd[k], 1'b0);
    i_i2c_host.stop();
    ce = 1'b0;
    wr_ready = 1'b1;
    repeat (3) @(posedge mclk);
    #1 check("freeze", {1'b1, wd[0]}, {wr_valid, wr_data});
    wr_ready = 1'b0;
    ce = 1'b1;
    for (int k = 0; k < 2; k++) begin
      check("head", {1'b1, wd[k]}, {wr_valid, wr_data});
      check("addr", {1'b0, 8'h10 + 8'(k)}, {1'b0, wr_addr});
      @(posedge mclk);
      #1 wr_ready = 1'b1;
      @(posedge mclk);
      #1 wr_ready = 1'b0;
    end
    check("drop", 9'h000, {8'h00, wr_valid});
    i_i2c_host.start();
    wbyte({own, 1'b0}, 1'b0);
    wbyte(8'h10, 1'b0);
    i_i2c_host.start();
    wbyte({own, 1'b1}, 1'b0);
    i_i2c_host.bits9(9'h1fe, q);
    check("rd0", {wd[0], 1'b0}, q);
    i_i2c_host.bits9(9'h1ff, q);
    check("rd1", {wd[1], 1'b1}, q);
    i_i2c_host.stop();
    check("idle", 9'h000, {8'h00, sda_oe});
    tally_and_finish();
  end
endmodule
